// File: core/canbuf_pkg.sv
// Constants, field layout and frame carrier for the CAN message buffer block
`default_nettype none
package canbuf_pkg;
  // Register index inside one message buffer window (byte address = index * 4)
  localparam logic [3:0] ID0_IDX      = 4'h0;
  localparam logic [3:0] ID1_IDX      = 4'h1;
  localparam logic [3:0] ID2_IDX      = 4'h2;
  localparam logic [3:0] ID3_IDX      = 4'h3;
  localparam logic [3:0] DATA_IDX     = 4'h4;
  localparam logic [3:0] LEN_IDX      = 4'hc;
  localparam logic [3:0] PRIORITY_VALUE_IDX     = 4'hd;
  localparam logic [3:0] STAMP_HI_IDX = 4'he;
  localparam logic [3:0] STAMP_LO_IDX = 4'hf;
  // Address windows selected by PADDR[7:6]
  localparam logic [1:0] WIN_TX  = 2'h0;
  localparam logic [1:0] WIN_RX  = 2'h1;
  localparam logic [1:0] WIN_CTL = 2'h2;
  // Control window register indices
  localparam logic [3:0] CTL_IDX   = 4'h0;
  localparam logic [3:0] SEL_IDX   = 4'h1;
  localparam logic [3:0] FLAG_IDX  = 4'h2;
  localparam logic [3:0] STAT_IDX  = 4'h3;
  localparam logic [3:0] TIMER_IDX = 4'h4;
  // Field positions
  localparam int ID1_RTR_BIT   = 4;
  localparam int ID1_IDE_BIT   = 3;
  localparam int CTL_INIT_BIT  = 0;
  localparam int CTL_TIME_BIT  = 1;
  localparam int STAT_BUSY_BIT = 4;
  // Reset values and limits
  localparam logic [1:0] CTL_RESET  = 2'h1;
  localparam logic [7:0] PRIORITY_VALUE_RESET = 8'h00;
  localparam logic [3:0] MAX_BYTES  = 4'h8;
  localparam int         NTX_DEF    = 3;
  localparam int         STAMP_W    = 16;

  // Transmit progress of the buffer handed to the bit engine
  typedef enum logic {TX_IDLE, TX_BUSY} tx_state_t;

  // Frame passed to / from the bit engine; id[10] goes on the wire first
  typedef struct packed {
    logic [10:0] id;
    logic        rtr;
    logic        ide;
    logic [3:0]  dlc;
    logic [3:0]  nbytes;
    logic [63:0] data;
  } frame_t;
endpackage
`default_nettype wire

// File: core/can_msg_buffers.sv
// CAN message buffers: transmit queue, receive buffer, time stamp, APB access
//
// The address map and the APB slave port were left to the implementer.
`default_nettype none
module can_msg_buffers #(
  parameter int NTX = canbuf_pkg::NTX_DEF          // Number of transmit buffers
) (
  input  wire logic              CLK,              // Controller clock, 50 MHz
  input  wire logic              RESETN,           // Async reset, active low
  input  wire logic              PSEL,             // APB select
  input  wire logic              PENABLE,          // APB access phase
  input  wire logic              PWRITE,           // APB write
  input  wire logic [7:0]        PADDR,            // APB byte address
  input  wire logic [31:0]       PWDATA,           // APB write data
  output logic      [31:0]       PRDATA,           // APB read data, registered
  output logic                   PREADY,           // APB ready, no wait states
  output logic                   PSLVERR,          // APB error on unmapped address
  input  wire logic              BIT_TICK,         // One pulse per CAN bit time
  input  wire logic              SOF_REQ,          // Engine about to send start of frame
  input  wire logic              TX_DONE,          // Own frame ended with valid EOF
  input  wire logic              RX_DONE,          // Received frame ended with valid EOF
  input  wire canbuf_pkg::frame_t RX_FRAME,        // Received frame, valid with RX_DONE
  output canbuf_pkg::frame_t     TX_FRAME,         // Frame chosen for sending
  output logic                   TX_FRAME_VALID,   // A buffer is handed to the engine
  output logic      [1:0]        TX_ACTIVE_IDX     // Index of handed-over buffer
);
  import canbuf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [7:0]         txm [NTX][16];               // Transmit buffers, no reset
  logic [7:0]         rxm [16];                    // Receive buffer, no reset
  logic [7:0]         priority_value_reg [NTX];              // Local priorities
  logic [NTX-1:0]     txe_reg;                     // Empty flags, 1 = free
  logic [1:0]         sel_reg;                     // Selected transmit buffer
  logic [1:0]         ctl_reg;                     // Init mode and stamp enable
  logic [STAMP_W-1:0] timer_reg;                   // Bit-time counter
  logic [1:0]         active_reg;                  // Buffer handed to engine
  tx_state_t          tx_state_reg;                // Hand-over progress
  frame_t             tx_frame_reg;                // Latched outgoing frame

  if (NTX < 1 || NTX > 4) begin : g_chk
    $error("NTX must lie between 1 and 4");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Data bytes that actually go on the wire for a given length and remote flag
  function automatic logic [3:0] byte_count(input logic [3:0] dlc, input logic rtr);
    if (rtr) begin
      byte_count = 4'h0;
    end else if (dlc > MAX_BYTES) begin
      byte_count = MAX_BYTES;
    end else begin
      byte_count = dlc;
    end
  endfunction

  // Internal prioritization among queued buffers
  logic       win_any;
  logic [1:0] win_idx;
  always_comb begin
    win_any = 1'b0;
    win_idx = 2'h0;
    // Strict less-than keeps the lower index on equal priority
    for (int i = 0; i < NTX; i++) begin
      if (!txe_reg[i] && (!win_any || priority_value_reg[i] < priority_value_reg[win_idx])) begin
        win_any = 1'b1;
        win_idx = 2'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic [1:0] win;
  logic [3:0] idx;
  logic       wr_acc;
  logic       setup;
  logic       mapped;
  logic       sel_free;
  // Window and register index come straight from the byte address
  assign win      = PADDR[7:6];
  assign idx      = PADDR[5:2];
  assign wr_acc   = PSEL && PENABLE && PWRITE && mapped;
  assign setup    = PSEL && !PENABLE;
  assign sel_free = txe_reg[sel_reg];
  assign mapped   = (win == WIN_TX) || (win == WIN_RX) || (win == WIN_CTL && idx <= TIMER_IDX);
  assign PREADY   = 1'b1;

  // Read data is prepared in the setup cycle so it leaves a flip-flop
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PSLVERR <= !mapped;
      PRDATA  <= 32'h0;
      case (win)
        WIN_TX: begin
          // Stamp of a sent frame is meaningful once the buffer is empty again
          if (idx == PRIORITY_VALUE_IDX) begin
            PRDATA <= {24'h0, priority_value_reg[sel_reg]};
          end else begin
            PRDATA <= {24'h0, txm[sel_reg][idx]};
          end
        end
        WIN_RX: begin
          PRDATA <= {24'h0, rxm[idx]};
        end
        WIN_CTL: begin
          case (idx)
            CTL_IDX:   PRDATA <= {30'h0, ctl_reg};
            SEL_IDX:   PRDATA <= {30'h0, sel_reg};
            FLAG_IDX:  PRDATA <= {{(32-NTX){1'b0}}, txe_reg};
            STAT_IDX:  PRDATA <= {27'h0, tx_state_reg == TX_BUSY, 2'h0, active_reg};
            TIMER_IDX: PRDATA <= {16'h0, timer_reg};
            default:   PRDATA <= 32'h0;
          endcase
        end
        default: begin
          PRDATA <= 32'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Init mode comes up set so the stamp counter starts from zero
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_reg <= CTL_RESET;
      sel_reg <= 2'h0;
    end else if (wr_acc && win == WIN_CTL) begin
      if (idx == CTL_IDX) begin
        ctl_reg <= PWDATA[1:0];
      end
      if (idx == SEL_IDX && PWDATA[1:0] < NTX) begin
        sel_reg <= PWDATA[1:0];
      end
    end
  end

  // Empty flags: software writes 1 to queue, end of frame frees; the free wins
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      txe_reg <= '1;
    end else begin
      for (int i = 0; i < NTX; i++) begin
        if (TX_DONE && tx_state_reg == TX_BUSY && active_reg == 2'(i)) begin
          txe_reg[i] <= 1'b1;
        end else if (wr_acc && win == WIN_CTL && idx == FLAG_IDX && PWDATA[i]) begin
          txe_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Local priority: writable only for the selected, empty buffer
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < NTX; i++) begin
        priority_value_reg[i] <= PRIORITY_VALUE_RESET;
      end
    end else if (wr_acc && win == WIN_TX && idx == PRIORITY_VALUE_IDX && sel_free) begin
      priority_value_reg[sel_reg] <= PWDATA[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time stamp counter

  // Wraps silently; no overflow flag is kept
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      timer_reg <= '0;
    end else if (ctl_reg[CTL_INIT_BIT]) begin
      timer_reg <= '0;
    end else if (BIT_TICK) begin
      timer_reg <= timer_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer RAM

  // No reset here: contents are undefined until written, as in RAM
  always_ff @(posedge CLK) begin
    // CPU fills id, data and length of the selected buffer while it is free
    if (wr_acc && win == WIN_TX && idx <= LEN_IDX && sel_free) begin
      txm[sel_reg][idx] <= PWDATA[7:0];
    end
    // Stamp bytes take no CPU write at all
    if (TX_DONE && tx_state_reg == TX_BUSY && ctl_reg[CTL_TIME_BIT]) begin
      txm[active_reg][STAMP_HI_IDX] <= timer_reg[15:8];
      txm[active_reg][STAMP_LO_IDX] <= timer_reg[7:0];
    end
  end

  // Receive buffer is written by the engine only
  always_ff @(posedge CLK) begin
    if (RX_DONE) begin
      rxm[ID0_IDX] <= RX_FRAME.id[10:3];
      rxm[ID1_IDX] <= {RX_FRAME.id[2:0], RX_FRAME.rtr, RX_FRAME.ide, 3'h0};
      rxm[LEN_IDX] <= {4'h0, RX_FRAME.dlc};
      for (int b = 0; b < 8; b++) begin
        rxm[DATA_IDX + 4'(b)] <= RX_FRAME.data[63-8*b -: 8];
      end
      if (ctl_reg[CTL_TIME_BIT]) begin
        rxm[STAMP_HI_IDX] <= timer_reg[15:8];
        rxm[STAMP_LO_IDX] <= timer_reg[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hand-over to the bit engine

  // Each start of frame re-runs the choice, so a lost or failed frame requeues
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_state_reg <= TX_IDLE;
      active_reg   <= 2'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (SOF_REQ && win_any) begin
            tx_state_reg <= TX_BUSY;
            active_reg   <= win_idx;
          end
        end
        TX_BUSY: begin
          // A finished frame beats a retry request in the same cycle
          if (TX_DONE) begin
            tx_state_reg <= TX_IDLE;
          end else if (SOF_REQ) begin
            tx_state_reg <= win_any ? TX_BUSY : TX_IDLE;
            active_reg   <= win_idx;
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Frame fields; id kept MSB first so the engine sends bit 10 first and the
  // lower numeric identifier dominates arbitration
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      tx_frame_reg <= '0;
    end else if (SOF_REQ && win_any) begin
      tx_frame_reg.id     <= {txm[win_idx][ID0_IDX], txm[win_idx][ID1_IDX][7:5]};
      tx_frame_reg.rtr    <= txm[win_idx][ID1_IDX][ID1_RTR_BIT];
      tx_frame_reg.ide    <= txm[win_idx][ID1_IDX][ID1_IDE_BIT];
      tx_frame_reg.dlc    <= txm[win_idx][LEN_IDX][3:0];
      tx_frame_reg.nbytes <= byte_count(txm[win_idx][LEN_IDX][3:0], txm[win_idx][ID1_IDX][ID1_RTR_BIT]);
      for (int b = 0; b < 8; b++) begin
        tx_frame_reg.data[63-8*b -: 8] <= txm[win_idx][DATA_IDX + 4'(b)];
      end
    end
  end

  // Outputs straight from the hand-over registers
  assign TX_FRAME       = tx_frame_reg;
  assign TX_FRAME_VALID = (tx_state_reg == TX_BUSY);
  assign TX_ACTIVE_IDX  = active_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // Queue state one cycle back, so a queue write landing with the start of frame
  // is not held against the choice that was made before it
  logic [NTX-1:0] txe_q;
  logic [7:0]     priority_value_q [NTX];
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      txe_q <= '1;
      for (int i = 0; i < NTX; i++) begin
        priority_value_q[i] <= PRIORITY_VALUE_RESET;
      end
    end else begin
      txe_q  <= txe_reg;
      priority_value_q <= priority_value_reg;
    end
  end

  // True when some buffer queued at the choice beats the one handed over
  function automatic logic beaten(input logic [1:0] a);
    beaten = 1'b0;
    for (int i = 0; i < NTX; i++) begin
      if (!txe_q[i] && (priority_value_q[i] < priority_value_q[a] || (priority_value_q[i] == priority_value_q[a] && 2'(i) < a))) begin
        beaten = 1'b1;
      end
    end
  endfunction

  chk_win_lowest: assert property (SOF_REQ && win_any |=> !beaten(active_reg) && TX_FRAME_VALID)
    else $error("Handed-over buffer is not the best queued one");
  chk_win_queued: assert property (SOF_REQ && win_any |=> !txe_reg[active_reg])
    else $error("Handed-over buffer was empty");
  chk_remote_nodata: assert property (TX_FRAME_VALID && TX_FRAME.rtr |-> TX_FRAME.nbytes == 4'h0)
    else $error("Remote frame carries data bytes");
  chk_count_limit: assert property (TX_FRAME_VALID && !TX_FRAME.rtr |-> TX_FRAME.nbytes <= MAX_BYTES)
    else $error("Byte count above eight");
  chk_id_layout: assert property (SOF_REQ && win_any |=> TX_FRAME.id[10:3] == txm[active_reg][ID0_IDX])
    else $error("Identifier high byte misplaced");
  chk_timer_init: assert property (ctl_reg[CTL_INIT_BIT] |=> timer_reg == '0)
    else $error("Timer not cleared in init mode");
  chk_timer_tick: assert property (!ctl_reg[CTL_INIT_BIT] && BIT_TICK |=> timer_reg == $past(timer_reg) + 1'b1)
    else $error("Timer did not count a bit time");
  chk_stamp_tx: assert property (TX_DONE && TX_FRAME_VALID && ctl_reg[CTL_TIME_BIT]
      |=> {txm[active_reg][STAMP_HI_IDX], txm[active_reg][STAMP_LO_IDX]} == $past(timer_reg))
    else $error("Transmit stamp not stored");
  chk_locked_write: assert property (wr_acc && win == WIN_TX && idx == ID0_IDX && !sel_free
      |=> txm[sel_reg][ID0_IDX] == $past(txm[sel_reg][ID0_IDX]))
    else $error("Queued buffer was overwritten");
  chk_priority_value_locked: assert property (wr_acc && win == WIN_TX && idx == PRIORITY_VALUE_IDX && !sel_free
      |=> $stable(priority_value_reg[sel_reg]))
    else $error("Priority changed while queued");

  // Frame contents, freeing, timer hold, stamp protection and receive side
  chk_length_kept: assert property (SOF_REQ && win_any |=> TX_FRAME.dlc == txm[active_reg][LEN_IDX][3:0])
    else $error("Length code not sent as programmed");
  chk_buffer_freed: assert property (TX_DONE && TX_FRAME_VALID |=> txe_reg[active_reg] && !TX_FRAME_VALID)
    else $error("Finished buffer not released");
  chk_timer_hold: assert property (!ctl_reg[CTL_INIT_BIT] && !BIT_TICK |=> $stable(timer_reg))
    else $error("Timer moved without a bit time");
  chk_rx_flags: assert property (RX_DONE
      |=> rxm[ID1_IDX] == {$past(RX_FRAME.id[2:0]), $past(RX_FRAME.rtr), $past(RX_FRAME.ide), 3'h0})
    else $error("Receive identifier byte one misplaced");
  chk_rx_stamp: assert property (RX_DONE && ctl_reg[CTL_TIME_BIT]
      |=> {rxm[STAMP_HI_IDX], rxm[STAMP_LO_IDX]} == $past(timer_reg))
    else $error("Receive stamp not stored");
  chk_stamp_readonly: assert property (wr_acc && win == WIN_TX && idx == STAMP_HI_IDX && !TX_DONE
      |=> $stable(txm[sel_reg][STAMP_HI_IDX]))
    else $error("CPU write reached a stamp byte");

  // Main scenarios: hand-over, tie, stamped receive, remote frame, retry start
  cov_handover: cover property (SOF_REQ && win_any ##1 TX_FRAME_VALID ##[1:50] TX_DONE);
  cov_tie: cover property (SOF_REQ && txe_reg[1:0] == 2'h0 && priority_value_reg[0] == priority_value_reg[1]);
  cov_rx_stamp: cover property (RX_DONE && ctl_reg[CTL_TIME_BIT]);
  cov_remote: cover property (TX_FRAME_VALID && TX_FRAME.rtr);
  cov_retry: cover property (TX_FRAME_VALID && SOF_REQ && win_any);
endmodule
`default_nettype wire

// File: test/can_bus_model.sv
// Bus-side engine model: bit ticks, own-frame handshakes and received frames
`default_nettype none
module can_bus_model (
  input  wire logic          CLK,      // Controller clock
  input  wire logic          RESETN,   // Async reset, active low
  output logic               BIT_TICK, // One pulse per bit time
  output logic               SOF_REQ,  // Start of frame comes next
  output logic               TX_DONE,  // Own frame ended cleanly
  output logic               RX_DONE,  // Received frame ended cleanly
  output canbuf_pkg::frame_t RX_FRAME  // Received frame, valid with RX_DONE
);
  timeunit 1ns;
  timeprecision 1ns;
  import canbuf_pkg::*;
  logic [1:0] div_reg;
  // Bit time cut to three clocks so stamps move within a short run
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      div_reg  <= 2'h0;
      BIT_TICK <= 1'b0;
    end else begin
      div_reg  <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
      BIT_TICK <= (div_reg == 2'h2);
    end
  end
  // Quiet link at time zero; the frame lines hold no valid frame
  initial begin
    SOF_REQ  = 1'b0;
    TX_DONE  = 1'b0;
    RX_DONE  = 1'b0;
    RX_FRAME = '1;
  end
  // Each pulse lasts exactly one clock
  task automatic sof();
    SOF_REQ <= 1'b1;
    @(posedge CLK);
    SOF_REQ <= 1'b0;
  endtask
  task automatic done();
    TX_DONE <= 1'b1;
    @(posedge CLK);
    TX_DONE <= 1'b0;
  endtask
  // Frame lines turn stale after the pulse, so nobody can lean on them
  task automatic rx(input frame_t f);
    RX_FRAME <= f;
    RX_DONE  <= 1'b1;
    @(posedge CLK);
    RX_DONE  <= 1'b0;
    RX_FRAME <= ~f;
  endtask
endmodule
`default_nettype wire

// File: test/tb_can_msg_buffers.sv
// Self-checking bench for the CAN message buffer block
`default_nettype none
module tb_can_msg_buffers;
  timeunit 1ns;
  timeprecision 1ns;
  import canbuf_pkg::*;
  logic        CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic        BIT_TICK, SOF_REQ, TX_DONE, RX_DONE, TX_FRAME_VALID, init_on;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [1:0]  TX_ACTIVE_IDX;
  frame_t      RX_FRAME, TX_FRAME;
  logic [15:0] tmr, tmr_at, stamp_exp;
  int          fails, compares;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic e;} row_t;
  // Reset values, refused and accepted writes and unmapped places, all while in init mode
  row_t rows [13] = '{'{1'b0, 8'h80, 32'h1, 1'b0}, '{1'b0, 8'h84, 32'h0, 1'b0},
    '{1'b0, 8'h88, 32'h7, 1'b0}, '{1'b0, 8'h90, 32'h0, 1'b0}, '{1'b0, 8'h34, 32'h0, 1'b0},
    '{1'b0, 8'h94, 32'h0, 1'b1}, '{1'b0, 8'hc0, 32'h0, 1'b1}, '{1'b1, 8'h84, 32'h3, 1'b0},
    '{1'b0, 8'h84, 32'h0, 1'b0}, '{1'b1, 8'h90, 32'h34, 1'b0}, '{1'b0, 8'h90, 32'h0, 1'b0},
    '{1'b1, 8'h34, 32'h9, 1'b0}, '{1'b0, 8'h34, 32'h9, 1'b0}};
  logic [10:0] ids   [3] = '{11'h123, 11'h05a, 11'h7f0};
  logic [3:0]  dlcs  [3] = '{4'hc, 4'h3, 4'h5};
  logic [3:0]  nbs   [3] = '{4'h8, 4'h3, 4'h0};
  logic [7:0]  prios [3] = '{8'h05, 8'h03, 8'h03};
  logic [1:0]  order [3] = '{2'h1, 2'h2, 2'h0};

  can_msg_buffers #(.NTX(3)) uut (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .BIT_TICK, .SOF_REQ, .TX_DONE, .RX_DONE, .RX_FRAME, .TX_FRAME, .TX_FRAME_VALID,
    .TX_ACTIVE_IDX);
  can_bus_model eng (.CLK, .RESETN, .BIT_TICK, .SOF_REQ, .TX_DONE, .RX_DONE, .RX_FRAME);

  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  // Reference timer; a read sees it at its setup edge, a stamp at frame end
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) tmr <= 16'h0000;
    else if (init_on) tmr <= 16'h0000;
    else if (BIT_TICK) tmr <= tmr + 16'h0001;
  end
  always @(posedge CLK) begin
    if (PSEL && !PENABLE) tmr_at <= tmr;
    if (TX_DONE || RX_DONE) stamp_exp <= tmr;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fails == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] x);
    compares++;
    if (s !== x) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  // One APB transfer; an idle cycle follows so strobes never toggle twice at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    // Ready, read data and error are all taken at the edge that ends the access
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (n >= 40) begin
      fails++;
      complete_run();
    end
    r = PRDATA;
    e = PSLVERR;
    if (w && a == 8'h80) init_on <= d[0];
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(nm, {32'h0, r}, {32'h0, x});
  endtask
  function automatic logic [63:0] dat(input int i);
    logic [63:0] v;
    for (int k = 0; k < 8; k++) v[63-8*k -: 8] = {i[3:0], k[3:0]};
    return v;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge CLK);
    fails++;
    complete_run();
  end
  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  mask;
    logic [63:0] v;
    int          b;
    RESETN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    init_on = 1'b1;
    fails = 0;
    compares = 0;
    repeat (20) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    for (int i = 0; i < 13; i++) begin
      xfer(rows[i].w, rows[i].a, rows[i].d, r, e);
      if (!rows[i].w && !rows[i].e) chk("row data", {32'h0, r}, {32'h0, rows[i].d});
      chk("row error", {63'h0, e}, {63'h0, rows[i].e});
    end
    // Leave init mode with stamping on, then fill and queue three buffers
    wr(8'h80, 32'h2);
    for (int i = 0; i < 3; i++) begin
      v = dat(i);
      wr(8'h84, 32'(i));
      wr(8'h00, {24'h0, ids[i][10:3]});
      wr(8'h04, {24'h0, ids[i][2:0], i == 2, i == 0, 3'h0});
      for (int k = 0; k < 8; k++) wr(8'h10 + 8'(4 * k), {24'h0, v[63-8*k -: 8]});
      wr(8'h30, {28'h0, dlcs[i]});
      wr(8'h34, {24'h0, prios[i]});
    end
    wr(8'h88, 32'h7);
    wr(8'h84, 32'h1);
    wr(8'h00, 32'hee);
    wr(8'h34, 32'h0);
    rdc("locked id", 8'h00, 32'h0b);
    rdc("locked priority_value", 8'h34, 32'h3);
    // Winners come out by priority, ties by index; each frame end frees and stamps
    mask = 8'h00;
    for (int o = 0; o < 3; o++) begin
      b = order[o];
      eng.sof();
      @(negedge CLK);
      chk("valid", TX_FRAME_VALID, 1'b1);
      chk("winner", TX_ACTIVE_IDX, order[o]);
      chk("tx id", TX_FRAME.id, ids[b]);
      chk("tx flags", {TX_FRAME.rtr, TX_FRAME.ide}, {b == 2, b == 0});
      chk("tx length", {TX_FRAME.dlc, TX_FRAME.nbytes}, {dlcs[b], nbs[b]});
      if (b != 2) chk("tx data", TX_FRAME.data, dat(b));
      @(posedge CLK);
      rdc("status busy", 8'h8c, 32'h10 + 32'(b));
      repeat (4) @(posedge CLK);
      eng.done();
      @(negedge CLK);
      chk("released", TX_FRAME_VALID, 1'b0);
      mask[b] = 1'b1;
      @(posedge CLK);
      rdc("empty flags", 8'h88, {24'h0, mask});
      wr(8'h84, 32'(b));
      wr(8'h38, 32'hff);
      rdc("stamp high", 8'h38, {24'h0, stamp_exp[15:8]});
      rdc("stamp low", 8'h3c, {24'h0, stamp_exp[7:0]});
    end
    eng.sof();
    @(negedge CLK);
    chk("idle start", TX_FRAME_VALID, 1'b0);
    @(posedge CLK);
    eng.rx('{11'h5a3, 1'b1, 1'b1, 4'h8, 4'h0, 64'h0102030405060708});
    @(posedge CLK);
    rdc("rx id0", 8'h40, 32'hb4);
    rdc("rx id1", 8'h44, 32'h78);
    rdc("rx data0", 8'h50, 32'h01);
    rdc("rx data7", 8'h6c, 32'h08);
    rdc("rx length", 8'h70, 32'h8);
    rdc("rx stamp", 8'h7c, {24'h0, stamp_exp[7:0]});
    xfer(1'b0, 8'h90, 32'h0, r, e);
    chk("timer", {32'h0, r}, {48'h0, tmr_at});
    wr(8'h80, 32'h1);
    rdc("timer in init", 8'h90, 32'h0);
    // A retry start re-runs the choice; a reset in mid-frame drops the hand-over
    wr(8'h88, 32'h1);
    eng.sof();
    @(posedge CLK);
    eng.sof();
    @(negedge CLK);
    chk("retry winner", {TX_FRAME_VALID, TX_ACTIVE_IDX}, 3'h4);
    @(posedge CLK);
    RESETN <= 1'b0;
    repeat (3) @(posedge CLK);
    RESETN <= 1'b1;
    @(negedge CLK);
    chk("reset valid", TX_FRAME_VALID, 1'b0);
    @(posedge CLK);
    rdc("reset flags", 8'h88, 32'h7);
    rdc("reset priority_value", 8'h34, 32'h0);
    rdc("reset control", 8'h80, 32'h1);
    complete_run();
  end
endmodule
`default_nettype wire
